//--- verilog/sps_regs_pkg.sv
package sps_regs_pkg;

  localparam logic [7:0] SPS_OFS_DP_CTRL2 = 8'h1A;
  localparam logic [7:0] SPS_OFS_CRC_ERRS = 8'h1B;
  localparam logic [7:0] SPS_OFS_PIN_LOW = 8'h1C;
  localparam logic [7:0] SPS_OFS_PIN_HIGH = 8'h1D;
  localparam logic [7:0] SPS_OFS_PORT_SEL = 8'h1E;

  // datapath_control_second fields
  localparam int SPS_DP_SURROUND_BIT = 0;
  localparam int SPS_DP_WIDE_BIT = 1;
  localparam int SPS_DP_AUX_AUDIO_BIT = 3;
  localparam logic [7:0] SPS_DP_WMASK = 8'h03;
  localparam logic [7:0] SPS_DP_RESET = 8'h01;

  // link_port_access_select fields
  localparam int SPS_SEL_PRIMARY_BIT = 0;
  localparam int SPS_SEL_SECONDARY_BIT = 1;
  localparam int SPS_SEL_SECOND_ADDR_BIT = 2;
  localparam logic [7:0] SPS_SEL_WMASK = 8'h07;
  localparam logic [7:0] SPS_SEL_RESET = 8'h01;

  // pin status layout
  localparam logic [7:0] SPS_PIN_LOW_MASK = 8'hEF;
  localparam logic [7:0] SPS_PIN_HIGH_MASK = 8'h01;
  localparam int SPS_PIN_COUNT = 9;
  localparam int SPS_PIN_HIGH_IDX = 8;

  localparam logic [7:0] SPS_CRC_RESET = 8'h00;
  localparam logic [7:0] SPS_CRC_MAX = 8'hFF;
  localparam logic [7:0] SPS_ZERO_BYTE = 8'h00;

  // added to the device id to form the secondary i2c address
  localparam logic [6:0] SPS_SECOND_ADDR_STEP = 7'h01;

  localparam int SPS_SYNC_STAGES = 2;

endpackage

//--- verilog/sps_sync2.sv
`timescale 1ns/100ps
module sps_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage; kept out of reset so that a
  // strap held through reset is already settled when reset is released
  always_ff @(posedge clk) begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end

  assign sync_out = sync_q;

endmodule

//--- verilog/sps_port_status_regs.sv
// Function
// - wide mode 0: 24 data bits plus three sync controls; 1: 28 data bits.
// - surround bit 0: 2 or 4 channel audio; 1: 5.1 or 7.1 channel audio.
// - surround audio only travels over the data-island I2S transport.
// - in a repeater, in-band I2S detection overrides the surround bit.
// - self-test return CRC errors counted in 8 bits, saturating at 255.
// - error counter clears on new self-test start or dedicated clear control.
// - low pin status: bits 0-3 and 5-7 show pin levels, bit 4 reserved.
// - high pin status: bit 0 shows pin 8 level, bits 7:1 reserved.
// - second-address enable makes device answer a second address for secondary port.
// - second address is the 7-bit device identifier plus one.
// - secondary select: primary address writes and reads secondary plus shared registers.
// - primary select: primary address writes and reads primary plus shared registers.
// - with both selects set, primary address reads return secondary registers.
// - port selects are ignored while second-address enable is set.
// - secondary audio bit is read-only, showing aux audio strapped at power-up.
`timescale 1ns/100ps
module sps_port_status_regs
  import sps_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // register access port from the i2c slave engine
  input wire logic [6:0] device_id,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [6:0] reg_target,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic reg_ack_q,
  output logic [7:0] reg_rdata_q,
  // pins
  input wire logic [8:0] io_pin_level,
  input wire logic mode_strap_input,
  // self-test error events
  input wire logic selftest_active,
  input wire logic selftest_crc_error,
  input wire logic selftest_crc_clear,
  // audio mode detection for repeater use
  input wire logic repeater_mode,
  input wire logic inband_surround_detect,
  // per-port datapath configuration, plus shared second-address enable and strapped aux audio
  output logic primary_wide_data_mode_q,
  output logic primary_sync_ctrl_carried_q,
  output logic primary_surround_audio_q,
  output logic primary_data_island_i2s_q,
  output logic secondary_wide_data_mode_q,
  output logic secondary_sync_ctrl_carried_q,
  output logic secondary_surround_audio_q,
  output logic secondary_data_island_i2s_q,
  output logic second_address_enable_q,
  output logic aux_audio_enable_q
);

  logic [7:0] dp_primary_q;
  logic [7:0] dp_secondary_q;
  logic [7:0] crc_errs_q;
  logic [7:0] port_sel_q;
  logic [7:0] pin_low_q;
  logic [7:0] pin_high_q;
  logic strap_taken_q;
  logic selftest_active_q;

  logic [9:0] pin_sync;
  logic [8:0] io_level_sync;
  logic strap_sync;

  logic [6:0] second_addr;
  logic hit_primary;
  logic hit_second;
  logic wr_primary_bank;
  logic wr_secondary_bank;
  logic rd_secondary_bank;
  logic do_write;
  logic do_read;
  logic selftest_start;
  logic [7:0] rdata_d;
  logic selects_bypassed;
  logic wr_dp_primary;
  logic wr_dp_secondary;
  logic wr_port_sel;
  logic crc_clear_event;
  logic crc_count_event;
  logic primary_surround_d;
  logic secondary_surround_d;

  function automatic logic [7:0] sps_dp_read(input logic [7:0] ctrl, input logic aux);
    logic [7:0] v;
    v = ctrl & SPS_DP_WMASK;
    v[SPS_DP_AUX_AUDIO_BIT] = aux;
    return v;
  endfunction

  function automatic logic sps_surround(input logic [7:0] ctrl, input logic rpt,
                                        input logic detect);
    logic s;
    s = ctrl[SPS_DP_SURROUND_BIT];
    if (rpt) begin
      s = detect;
    end
    return s;
  endfunction

  // register offset match shared by the write strobes
  function automatic logic sps_at(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // saturating step of the error counter, never wraps past the top
  function automatic logic [7:0] sps_sat_inc(input logic [7:0] v);
    logic [7:0] n;
    n = v;
    if (v != SPS_CRC_MAX) begin
      n = v + 8'h01;
    end
    return n;
  endfunction

  sps_sync2 #(
    .WIDTH(10)
  ) u_pin_sync (
    .clk(clk),
    .async_in({mode_strap_input, io_pin_level}),
    .sync_out(pin_sync)
  );

  assign io_level_sync = pin_sync[8:0];
  assign strap_sync = pin_sync[9];

  // address decode
  assign second_addr = 7'(device_id + SPS_SECOND_ADDR_STEP);
  assign selects_bypassed = port_sel_q[SPS_SEL_SECOND_ADDR_BIT];
  assign hit_primary = (reg_target == device_id);
  assign hit_second = selects_bypassed && (reg_target == second_addr);
  assign do_write = reg_req && reg_wr && (hit_primary || hit_second);
  assign do_read = reg_req && !reg_wr && (hit_primary || hit_second);

  // write strobes, one per writable register
  assign wr_dp_primary = do_write && wr_primary_bank && sps_at(reg_addr, SPS_OFS_DP_CTRL2);
  assign wr_dp_secondary = do_write && wr_secondary_bank && sps_at(reg_addr, SPS_OFS_DP_CTRL2);
  assign wr_port_sel = do_write && sps_at(reg_addr, SPS_OFS_PORT_SEL);

  always_comb begin
    wr_primary_bank = 1'b0;
    wr_secondary_bank = 1'b0;
    rd_secondary_bank = 1'b0;
    if (hit_second) begin
      wr_secondary_bank = 1'b1;
      rd_secondary_bank = 1'b1;
    end else if (hit_primary) begin
      if (selects_bypassed) begin
        wr_primary_bank = 1'b1;
        rd_secondary_bank = 1'b0;
      end else begin
        wr_primary_bank = port_sel_q[SPS_SEL_PRIMARY_BIT];
        wr_secondary_bank = port_sel_q[SPS_SEL_SECONDARY_BIT];
        rd_secondary_bank = port_sel_q[SPS_SEL_SECONDARY_BIT];
      end
    end
  end

  // per-port datapath control
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_primary_q <= SPS_DP_RESET;
    end else if (wr_dp_primary) begin
      dp_primary_q <= reg_wdata & SPS_DP_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dp_secondary_q <= SPS_DP_RESET;
    end else if (wr_dp_secondary) begin
      dp_secondary_q <= reg_wdata & SPS_DP_WMASK;
    end
  end

  // shared port-select register
  always_ff @(posedge clk) begin
    if (rst) begin
      port_sel_q <= SPS_SEL_RESET;
    end else if (wr_port_sel) begin
      port_sel_q <= reg_wdata & SPS_SEL_WMASK;
    end
  end

  // strap caught once after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_taken_q <= 1'b0;
      aux_audio_enable_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      aux_audio_enable_q <= strap_sync;
    end
  end

  // self-test return CRC error counter
  always_ff @(posedge clk) begin
    if (rst) begin
      selftest_active_q <= 1'b0;
    end else begin
      selftest_active_q <= selftest_active;
    end
  end

  assign selftest_start = selftest_active && !selftest_active_q;

  // counter events; errors outside a self-test are not counted
  assign crc_clear_event = selftest_start || selftest_crc_clear;
  assign crc_count_event = selftest_active && selftest_crc_error;

  always_ff @(posedge clk) begin
    if (rst) begin
      crc_errs_q <= SPS_CRC_RESET;
    end else if (crc_clear_event) begin
      // an error in the clearing cycle is still counted
      if (crc_count_event) begin
        crc_errs_q <= SPS_CRC_RESET + 8'h01;
      end else begin
        crc_errs_q <= SPS_CRC_RESET;
      end
    end else if (crc_count_event) begin
      crc_errs_q <= sps_sat_inc(crc_errs_q);
    end
  end

  // pin status capture
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_low_q <= SPS_ZERO_BYTE;
    end else begin
      pin_low_q <= io_level_sync[7:0] & SPS_PIN_LOW_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_high_q <= SPS_ZERO_BYTE;
    end else begin
      pin_high_q <= {7'h00, io_level_sync[SPS_PIN_HIGH_IDX]} & SPS_PIN_HIGH_MASK;
    end
  end

  // read data
  always_comb begin
    rdata_d = SPS_ZERO_BYTE;
    case (reg_addr)
      SPS_OFS_DP_CTRL2: begin
        if (rd_secondary_bank) begin
          rdata_d = sps_dp_read(dp_secondary_q, aux_audio_enable_q);
        end else begin
          rdata_d = sps_dp_read(dp_primary_q, aux_audio_enable_q);
        end
      end
      SPS_OFS_CRC_ERRS: rdata_d = crc_errs_q;
      SPS_OFS_PIN_LOW: rdata_d = pin_low_q;
      SPS_OFS_PIN_HIGH: rdata_d = pin_high_q;
      SPS_OFS_PORT_SEL: rdata_d = port_sel_q;
      default: rdata_d = SPS_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_ack_q <= 1'b0;
    end else begin
      reg_ack_q <= do_write || do_read;
    end
  end

  // read data stands only in the ack cycle of a read
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= SPS_ZERO_BYTE;
    end else if (do_read) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= SPS_ZERO_BYTE;
    end
  end

  // effective surround per port; the repeater override reaches both ports
  assign primary_surround_d = sps_surround(dp_primary_q, repeater_mode,
                                           inband_surround_detect);
  assign secondary_surround_d = sps_surround(dp_secondary_q, repeater_mode,
                                             inband_surround_detect);

  // data width per port
  always_ff @(posedge clk) begin
    if (rst) begin
      primary_wide_data_mode_q <= 1'b0;
      primary_sync_ctrl_carried_q <= 1'b1;
    end else begin
      primary_wide_data_mode_q <= dp_primary_q[SPS_DP_WIDE_BIT];
      primary_sync_ctrl_carried_q <= !dp_primary_q[SPS_DP_WIDE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      secondary_wide_data_mode_q <= 1'b0;
      secondary_sync_ctrl_carried_q <= 1'b1;
    end else begin
      secondary_wide_data_mode_q <= dp_secondary_q[SPS_DP_WIDE_BIT];
      secondary_sync_ctrl_carried_q <= !dp_secondary_q[SPS_DP_WIDE_BIT];
    end
  end

  // surround audio always rides the data-island transport
  always_ff @(posedge clk) begin
    if (rst) begin
      primary_surround_audio_q <= 1'b0;
      primary_data_island_i2s_q <= 1'b0;
    end else begin
      primary_surround_audio_q <= primary_surround_d;
      primary_data_island_i2s_q <= primary_surround_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      secondary_surround_audio_q <= 1'b0;
      secondary_data_island_i2s_q <= 1'b0;
    end else begin
      secondary_surround_audio_q <= secondary_surround_d;
      secondary_data_island_i2s_q <= secondary_surround_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      second_address_enable_q <= 1'b0;
    end else begin
      second_address_enable_q <= port_sel_q[SPS_SEL_SECOND_ADDR_BIT];
    end
  end

endmodule

//--- testbench/sps_regs_props.sv
`timescale 1ns/100ps
module sps_regs_props
  import sps_regs_pkg::*;
(
  input logic clk,
  input logic rst,
  input logic [6:0] device_id,
  input logic reg_req,
  input logic reg_wr,
  input logic [6:0] reg_target,
  input logic [7:0] reg_addr,
  input logic reg_ack_q,
  input logic [7:0] reg_rdata_q,
  input logic repeater_mode,
  input logic inband_surround_detect,
  input logic primary_wide_data_mode_q,
  input logic primary_sync_ctrl_carried_q,
  input logic primary_surround_audio_q,
  input logic primary_data_island_i2s_q,
  input logic second_address_enable_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire own = reg_req && reg_target == device_id;
  wire alt = reg_req && reg_target == device_id + 7'h01;
  own_ack_a: assert property (own |=> reg_ack_q)
    else $error("own access not acked");
  foreign_drop_a: assert property (reg_req && !own && !alt |=> !reg_ack_q)
    else $error("foreign access acked");
  second_ack_a: assert property (alt ##1 second_address_enable_q |-> reg_ack_q)
    else $error("second address not acked");
  rdata_idle_a: assert property (!reg_ack_q || $past(reg_wr) |-> reg_rdata_q == 8'h00)
    else $error("read data outside read ack");
  pin_high_rsvd_a: assert property (own && !reg_wr && reg_addr == SPS_OFS_PIN_HIGH
    |=> reg_rdata_q[7:1] == 7'h00) else $error("pin status high bits set");
  wide_sync_a: assert property (primary_sync_ctrl_carried_q != primary_wide_data_mode_q)
    else $error("wide mode and sync carry agree");
  surround_island_a: assert property (primary_data_island_i2s_q == primary_surround_audio_q)
    else $error("surround without data island");
  repeater_override_a: assert property (!$past(rst) && $past(repeater_mode)
    |-> primary_surround_audio_q == $past(inband_surround_detect)) else $error("no override");
endmodule
bind sps_port_status_regs sps_regs_props sps_regs_props_inst (.*);

//--- testbench/sps_host_model.sv
`timescale 1ns/100ps
module sps_host_model (
  input logic clk,
  output logic reg_req,
  output logic reg_wr,
  output logic [6:0] reg_target,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {reg_req, reg_wr, reg_target, reg_addr, reg_wdata} = '0;
  // pin status used only for input pins, second address set before remote use
  task automatic xfer(input logic w, input logic [6:0] t, input logic [7:0] a, d);
    @(posedge clk);
    reg_req <= 1'b1;
    reg_wr <= w;
    reg_target <= t;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  // released address and write-data lines toggle so stale values never look live
  task automatic idle();
    @(posedge clk);
    reg_req <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask
endmodule

//--- testbench/sps_port_status_regs_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("mismatch %0t %h %h", $time, a, e); \
  end \
end
module sps_port_status_regs_tb_top
  import sps_regs_pkg::*;
;
  logic clk, rst, reg_req, reg_wr, reg_ack_q, mode_strap_input, selftest_active;
  logic selftest_crc_error, selftest_crc_clear, repeater_mode, inband_surround_detect;
  logic primary_wide_data_mode_q, primary_sync_ctrl_carried_q, primary_surround_audio_q;
  logic primary_data_island_i2s_q, secondary_wide_data_mode_q, secondary_surround_audio_q;
  logic secondary_sync_ctrl_carried_q, secondary_data_island_i2s_q, second_address_enable_q;
  logic aux_audio_enable_q;
  logic [6:0] device_id, reg_target, id1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, exp_v;
  logic [8:0] io_pin_level;
  logic [7:0] q[$];
  int mismatches, check_count, cyc;
  integer seed;
  assign id1 = device_id + 7'h01;
  sps_port_status_regs sps_port_status_regs_inst (.*);
  sps_host_model sps_host_model_inst (.*);
  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [6:0] t, input logic [7:0] a, d, e);
    q.push_back(e);
    sps_host_model_inst.xfer(w, t, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    acc(1'b0, device_id, a, 8'h00, e);
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1'b1, device_id, a, d, 8'h00);
  endtask
  task automatic pause(input int n);
    sps_host_model_inst.idle();
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge clk);
      selftest_crc_error <= 1'b1;
      @(posedge clk);
      selftest_crc_error <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask
  always @(negedge clk) begin
    if (reg_ack_q !== 1'b0) begin
      if (q.size() == 0) begin
        `CHK(reg_ack_q, 1'b0)
      end else begin
        exp_v = q.pop_front();
        `CHK(reg_rdata_q, exp_v)
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    seed = 32'h2A41;
    device_id = 7'($random(seed));
    {rst, mode_strap_input, selftest_active, selftest_crc_error} = 4'hC;
    {selftest_crc_clear, repeater_mode, inband_surround_detect} = 3'h0;
    io_pin_level = 9'h000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h1E, 8'h01);
    rd(8'h1A, 8'h09);
    rd(8'h1B, 8'h00);
    wr(8'h1A, 8'hFE);
    wr(8'h1B, 8'h55);
    rd(8'h1A, 8'h0A);
    rd(8'h1B, 8'h00);
    rd(8'h40, 8'h00);
    pause(2);
    `CHK(aux_audio_enable_q, 1'b1)
    `CHK(primary_wide_data_mode_q, 1'b1)
    `CHK(primary_sync_ctrl_carried_q, 1'b0)
    wr(8'h1E, 8'hF9);
    rd(8'h1E, 8'h01);
    wr(8'h1E, 8'h02);
    wr(8'h1A, 8'h03);
    rd(8'h1A, 8'h0B);
    wr(8'h1E, 8'h01);
    rd(8'h1A, 8'h0A);
    wr(8'h1E, 8'h03);
    rd(8'h1A, 8'h0B);
    wr(8'h1A, 8'h01);
    wr(8'h1E, 8'h01);
    rd(8'h1A, 8'h09);
    pause(2);
    `CHK(primary_surround_audio_q, 1'b1)
    `CHK(secondary_surround_audio_q, 1'b1)
    `CHK(secondary_data_island_i2s_q, 1'b1)
    `CHK(secondary_sync_ctrl_carried_q, 1'b1)
    `CHK(secondary_wide_data_mode_q, 1'b0)
    sps_host_model_inst.xfer(1'b0, id1, 8'h1E, 8'h00);
    sps_host_model_inst.xfer(1'b0, device_id + 7'h05, 8'h1E, 8'h00);
    wr(8'h1E, 8'h06);
    acc(1'b1, id1, 8'h1A, 8'h02, 8'h00);
    rd(8'h1A, 8'h09);
    acc(1'b0, id1, 8'h1A, 8'h00, 8'h0A);
    acc(1'b0, id1, 8'h1E, 8'h00, 8'h06);
    pause(1);
    `CHK(second_address_enable_q, 1'b1)
    `CHK(secondary_wide_data_mode_q, 1'b1)
    `CHK(secondary_sync_ctrl_carried_q, 1'b0)
    `CHK(secondary_surround_audio_q, 1'b0)
    `CHK(secondary_data_island_i2s_q, 1'b0)
    wr(8'h1E, 8'h01);
    pause(0);
    repeat (3) begin
      @(posedge clk);
      io_pin_level <= 9'($random(seed));
      repeat (5) @(posedge clk);
      rd(8'h1C, {io_pin_level[7:5], 1'b0, io_pin_level[3:0]});
      rd(8'h1D, {7'h00, io_pin_level[8]});
      pause(0);
    end
    @(posedge clk);
    selftest_active <= 1'b1;
    repeat (3) @(posedge clk);
    errs(3);
    rd(8'h1B, 8'h03);
    pause(0);
    errs(300);
    rd(8'h1B, 8'hFF);
    pause(0);
    @(posedge clk);
    selftest_crc_clear <= 1'b1;
    @(posedge clk);
    selftest_crc_clear <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h1B, 8'h00);
    pause(0);
    errs(2);
    selftest_active <= 1'b0;
    @(posedge clk);
    selftest_active <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h1B, 8'h00);
    pause(0);
    @(posedge clk);
    repeater_mode <= 1'b1;
    repeat (6) begin
      @(posedge clk);
      inband_surround_detect <= 1'($random(seed));
    end
    pause(3);
    `CHK(primary_surround_audio_q, inband_surround_detect)
    `CHK(q.size(), 0)
    wrap_up();
  end
endmodule
